// [sqt_buf.sv]
`timescale 1ns/1ps
`default_nettype none
module sqt_buf
#(
    parameter int W     = 8,
    parameter int DEPTH = 2
)
(
    input  wire logic   clk_i,
    input  wire logic   rst_b_i,
    sqt_stream_if.store s
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0]  slot_ff [DEPTH];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0]   cnt_ff;
    wire           take = s.in_valid & s.in_ready;
    wire           give = s.out_valid & s.out_ready;

    // Honest full and empty from the entry count.
    assign s.in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign s.out_valid = (cnt_ff != '0);
    assign s.out_data  = slot_ff[rp_ff];

    always_ff @(posedge clk_i)
    begin
        if (take)
        begin
            slot_ff[wp_ff] <= s.in_data;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (take)
            begin
                wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
            end
            if (give)
            begin
                rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(take) - (AW+1)'(give);
        end
    end
endmodule : sqt_buf
`default_nettype wire

// [sqt_host.sv]
`timescale 1ns/1ps
`default_nettype none
module sqt_host
    import sqt_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output var  logic [7:0] addr_o,
    output var  logic [7:0] wdata_o,
    output var  logic       wr_o,
    output var  logic       rd_o,
    output var  logic       tick_o
);
    initial
    begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        tick_o = 1'b0;
    end
    // Idle bus lines show the inverse of the last value.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        d = rdata_i;
        rd_o = 1'b0;
        addr_o = ~a;
    endtask : rd
    // Trim update keeps bit 0 by read-modify-write.
    task automatic trim_set(input int ax, input logic [14:0] v);
        logic [7:0] lo;
        rd(ADDR_TRIM_LO[ax], lo);
        wr(ADDR_TRIM_HI[ax], v[14:7]);
        wr(ADDR_TRIM_LO[ax], {v[6:0], lo[0]});
    endtask : trim_set
    // Reads the port until the empty marker shows.
    task automatic drain(output logic [7:0] q[$]);
        logic [7:0] v;
        q.delete();
        for (int i = 0; i < 40; i++)
        begin
            rd(ADDR_PORT, v);
            if (v == EMPTY_MARK)
                break;
            q.push_back(v);
        end
    endtask : drain
    // One sample tick; the line stands low between frames.
    task automatic frame();
        #3;
        tick_o = 1'b1;
        #80;
        tick_o = 1'b0;
        #80;
    endtask : frame
endmodule : sqt_host
`default_nettype wire

// [sqt_pkg.sv]
// Behaviour
// - Port read pops next byte; write stores one.
// - Sample bytes queued lowest source first.
// - Byte captured only when its flag set.
// - All flags set: fourteen bytes per tick.
// - Overflow raises the overrun status flag.
// - Overflow drops oldest unless stop mode set.
// - Empty queue reads back as all ones.
// - Stored bytes never equal the empty marker.
// - Read-only identity register holds fixed code.
// - Bus address low bit follows select pin.
// - Trim bits 14..7 fill high register.
// - Trim bits 6..0 fill low bits 7..1.
// - Low register bit 0 keeps factory value.
// - Trim step scales with range: left shift by 4 minus range.
// - Upper count read latches the count for the lower byte; upper byte reads live.
package sqt_pkg;
    localparam logic [7:0] ADDR_COUNT_HI = 8'h72;
    localparam logic [7:0] ADDR_COUNT_LO = 8'h73;
    localparam logic [7:0] ADDR_PORT     = 8'h74;
    localparam logic [7:0] ADDR_IDENT    = 8'h75;
    localparam logic [7:0] ADDR_TRIM_HI [3] = '{8'h77, 8'h7A, 8'h7D};
    localparam logic [7:0] ADDR_TRIM_LO [3] = '{8'h78, 8'h7B, 8'h7E};
    localparam logic [7:0] EMPTY_MARK    = 8'hFF;
    localparam logic [7:0] MARK_SUBST    = 8'hFE;
    localparam logic [5:0] I2C_ADDR_HI   = 6'h34;
    localparam int         QUEUE_DEPTH   = 4096;
    localparam int         SRC_COUNT     = 14;
    localparam int         ACCEL_BYTES   = 6;
    localparam int         AXES          = 3;
    localparam logic [2:0] TRIM_SHIFT_MAX = 3'h4;
    localparam int         COUNT_HI_POS  = 8;
    localparam int         BUF_DEPTH     = 2;

    function automatic logic [7:0] no_marker(input logic [7:0] b);
        no_marker = (b == EMPTY_MARK) ? MARK_SUBST : b;
    endfunction : no_marker
endpackage : sqt_pkg

// [sqt_stream_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface sqt_stream_if #(parameter int W = 8);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;
    modport feed  (output in_valid, output in_data, output out_ready,
                   input in_ready, input out_valid, input out_data);
    modport store (input in_valid, input in_data, input out_ready,
                   output in_ready, output out_valid, output out_data);
endinterface : sqt_stream_if
`default_nettype wire

// [sqt_top.sv]
`timescale 1ns/1ps
`default_nettype none
module sqt_top
    import sqt_pkg::*;
#(
    parameter int         DEPTH        = QUEUE_DEPTH,
    // Arbitrary identity value.
    parameter logic [7:0] ID_CODE      = 8'h5A,
    parameter logic [2:0] FACTORY_BIT0 = 3'h0
)
(
    input  wire logic        CLOCK_I,
    input  wire logic        RST_B_I,
    input  wire logic [7:0]  REG_ADDR_I,
    input  wire logic [7:0]  REG_WDATA_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    output var  logic [7:0]  REG_RDATA_O,
    input  wire logic        SAMPLE_TICK_I,
    input  wire logic        ADDR_SEL_PIN_I,
    input  wire logic [13:0] CAPTURE_EN_I,
    input  wire logic        STOP_WHEN_FULL_I,
    input  wire logic [1:0]  ACCEL_RANGE_I,
    input  wire logic [47:0] ACCEL_RAW_I,
    input  wire logic [63:0] OTHER_DATA_I,
    output var  logic [47:0] ACCEL_OUT_O,
    output var  logic        QUEUE_OVERRUN_FLAG_O,
    output var  logic [6:0]  I2C_ADDR_O
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
        hit = (a == want);
    endfunction : hit

    function automatic logic [15:0] sat16(input logic signed [19:0] v);
        if (v > 20'sh07FFF)
        begin
            sat16 = 16'h7FFF;
        end
        else if (v < -20'sh08000)
        begin
            sat16 = 16'h8000;
        end
        else
        begin
            sat16 = v[15:0];
        end
    endfunction : sat16

    typedef enum logic {SQ_IDLE, SQ_RUN} sqt_seq_t;

    ////////////////////////////////////////////////////////////////////////
    // Pin inputs pass three flip-flops.

    logic [2:0] tick_sync_ff;
    logic [2:0] sel_sync_ff;
    logic       tick_lvl_ff;
    logic       sel_lvl_ff;

    always_ff @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            tick_sync_ff <= 3'h0;
            sel_sync_ff  <= 3'h0;
            tick_lvl_ff  <= 1'b0;
            sel_lvl_ff   <= 1'b0;
        end
        else
        begin
            tick_sync_ff <= {tick_sync_ff[1:0], SAMPLE_TICK_I};
            sel_sync_ff  <= {sel_sync_ff[1:0], ADDR_SEL_PIN_I};
            if (tick_sync_ff[1] == tick_sync_ff[2])
            begin
                tick_lvl_ff <= tick_sync_ff[2];
            end
            if (sel_sync_ff[1] == sel_sync_ff[2])
            begin
                sel_lvl_ff <= sel_sync_ff[2];
            end
        end
    end

    wire tick_rise = (tick_sync_ff[1] == tick_sync_ff[2]) & tick_sync_ff[2] & ~tick_lvl_ff;

    ////////////////////////////////////////////////////////////////////////
    // Register decode.

    wire port_rd  = REG_RD_I & hit(REG_ADDR_I, ADDR_PORT);
    wire port_wr  = REG_WR_I & hit(REG_ADDR_I, ADDR_PORT);
    wire cnt_hi_rd = REG_RD_I & hit(REG_ADDR_I, ADDR_COUNT_HI);

    ////////////////////////////////////////////////////////////////////////
    // Accel trim registers and trim path.

    logic [7:0]  trim_hi_ff [AXES];
    logic [6:0]  trim_lo_ff [AXES];
    logic [15:0] accel_ff   [AXES];
    logic [7:0]  trim_lo_rd [AXES];
    wire  [2:0]  trim_sh = TRIM_SHIFT_MAX - {1'b0, ACCEL_RANGE_I};

    genvar ax;
    generate
        for (ax = 0; ax < AXES; ax++)
        begin : g_axis
            wire hi_wr = REG_WR_I & hit(REG_ADDR_I, ADDR_TRIM_HI[ax]);
            wire lo_wr = REG_WR_I & hit(REG_ADDR_I, ADDR_TRIM_LO[ax]);
            wire signed [14:0] trim = {trim_hi_ff[ax], trim_lo_ff[ax]};
            wire signed [19:0] t_ext = 20'(trim);
            wire signed [19:0] t_scl = t_ext <<< trim_sh;
            wire signed [19:0] raw = 20'($signed(ACCEL_RAW_I[ax*16 +: 16]));
            wire signed [19:0] sum = raw + t_scl;
            assign trim_lo_rd[ax] = {trim_lo_ff[ax], FACTORY_BIT0[ax]};

            always_ff @(posedge CLOCK_I or negedge RST_B_I)
            begin
                if (!RST_B_I)
                begin
                    trim_hi_ff[ax] <= 8'h00;
                    trim_lo_ff[ax] <= 7'h00;
                    accel_ff[ax]   <= 16'h0000;
                end
                else
                begin
                    if (hi_wr)
                    begin
                        trim_hi_ff[ax] <= REG_WDATA_I;
                    end
                    if (lo_wr)
                    begin
                        trim_lo_ff[ax] <= REG_WDATA_I[7:1];
                    end
                    accel_ff[ax] <= sat16(sum);
                end
            end
        end
    endgenerate
    assign ACCEL_OUT_O = {accel_ff[2], accel_ff[1], accel_ff[0]};

    ////////////////////////////////////////////////////////////////////////
    // Sample source bytes, lowest source first.

    logic [7:0] src_byte [SRC_COUNT];
    genvar sb;
    generate
        for (sb = 0; sb < SRC_COUNT; sb++)
        begin : g_src
            if (sb < ACCEL_BYTES)
            begin : g_acc
                assign src_byte[sb] = (sb % 2 == 0) ? accel_ff[sb/2][15:8]
                                                    : accel_ff[sb/2][7:0];
            end
            else
            begin : g_oth
                assign src_byte[sb] = OTHER_DATA_I[(SRC_COUNT-1-sb)*8 +: 8];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Capture sequencer feeding the two-entry buffer.

    sqt_stream_if #(.W(8)) q ();

    sqt_seq_t   state_ff;
    sqt_seq_t   nxt_state;
    logic [7:0] snap_ff [SRC_COUNT];
    logic [13:0] mask_ff;
    logic [3:0] idx_ff;
    logic [3:0] nxt_idx;

    wire   cur_en  = mask_ff[idx_ff];
    wire   advance = (state_ff == SQ_RUN) & (~cur_en | q.in_ready);
    wire   last    = (idx_ff == 4'(SRC_COUNT-1));
    assign q.in_valid = (state_ff == SQ_RUN) & cur_en;
    assign q.in_data  = no_marker(snap_ff[idx_ff]);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_idx   = idx_ff;
        case (state_ff)
            SQ_IDLE:
            begin
                if (tick_rise & (|CAPTURE_EN_I))
                begin
                    nxt_state = SQ_RUN;
                    nxt_idx   = 4'h0;
                end
            end
            SQ_RUN:
            begin
                if (advance)
                begin
                    nxt_idx   = idx_ff + 4'h1;
                    nxt_state = last ? SQ_IDLE : SQ_RUN;
                end
            end
            default:
            begin
                nxt_state = SQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            state_ff <= SQ_IDLE;
            idx_ff   <= 4'h0;
            mask_ff  <= 14'h0000;
        end
        else
        begin
            state_ff <= nxt_state;
            idx_ff   <= nxt_idx;
            if (state_ff == SQ_IDLE && nxt_state == SQ_RUN)
            begin
                mask_ff <= CAPTURE_EN_I;
            end
        end
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (state_ff == SQ_IDLE && nxt_state == SQ_RUN)
        begin
            snap_ff <= src_byte;
        end
    end

    sqt_buf #(.W(8), .DEPTH(BUF_DEPTH)) u_buf (
        .clk_i   (CLOCK_I),
        .rst_b_i (RST_B_I),
        .s       (q.store)
    );

    ////////////////////////////////////////////////////////////////////////
    // Queue storage.

    logic [7:0]    mem_ff [DEPTH];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [CW-1:0] count_ff;
    logic [CW-1:0] count_lat_ff;
    logic          ovf_ff;

    assign q.out_ready = ~(port_rd | port_wr);
    wire   push        = port_wr | (q.out_valid & q.out_ready);
    wire   [7:0] pdata = port_wr ? no_marker(REG_WDATA_I) : q.out_data;
    wire   empty       = (count_ff == '0);
    wire   full        = (count_ff == CW'(DEPTH));
    wire   pop         = port_rd & ~empty;
    wire   overflow    = push & full & ~pop;
    wire   do_write    = push & ~(overflow & STOP_WHEN_FULL_I);
    wire   drop_old    = overflow & ~STOP_WHEN_FULL_I;
    wire   rd_adv      = pop | drop_old;

    always_ff @(posedge CLOCK_I)
    begin
        if (do_write)
        begin
            mem_ff[wp_ff] <= pdata;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            wp_ff        <= '0;
            rp_ff        <= '0;
            count_ff     <= '0;
            count_lat_ff <= '0;
            ovf_ff       <= 1'b0;
        end
        else
        begin
            if (do_write)
            begin
                wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
            end
            if (rd_adv)
            begin
                rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
            end
            count_ff <= count_ff + CW'(do_write & ~drop_old) - CW'(pop);
            if (cnt_hi_rd)
            begin
                count_lat_ff <= count_ff;
            end
            ovf_ff <= overflow;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and address output.

    logic [7:0] rd_mux;
    always_comb
    begin
        rd_mux = 8'h00;
        if (hit(REG_ADDR_I, ADDR_PORT))
        begin
            rd_mux = empty ? EMPTY_MARK : mem_ff[rp_ff];
        end
        else if (hit(REG_ADDR_I, ADDR_IDENT))
        begin
            rd_mux = ID_CODE;
        end
        else if (hit(REG_ADDR_I, ADDR_COUNT_HI))
        begin
            rd_mux = 8'(count_ff >> COUNT_HI_POS);
        end
        else if (hit(REG_ADDR_I, ADDR_COUNT_LO))
        begin
            rd_mux = 8'(count_lat_ff);
        end
        else
        begin
            for (int a = 0; a < AXES; a++)
            begin
                if (hit(REG_ADDR_I, ADDR_TRIM_HI[a]))
                begin
                    rd_mux = trim_hi_ff[a];
                end
                if (hit(REG_ADDR_I, ADDR_TRIM_LO[a]))
                begin
                    rd_mux = trim_lo_rd[a];
                end
            end
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            REG_RDATA_O <= 8'h00;
            I2C_ADDR_O  <= {I2C_ADDR_HI, 1'b0};
        end
        else
        begin
            if (REG_RD_I)
            begin
                REG_RDATA_O <= rd_mux;
            end
            I2C_ADDR_O <= {I2C_ADDR_HI, sel_lvl_ff};
        end
    end

    assign QUEUE_OVERRUN_FLAG_O = ovf_ff;
endmodule : sqt_top
`default_nettype wire

// [sqt_top_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module sqt_chk
    import sqt_pkg::*;
#(
    // Arbitrary identity value.
    parameter logic [7:0] ID_CODE      = 8'h5A,
    parameter logic [2:0] FACTORY_BIT0 = 3'h0
)
(
    input wire logic        CLOCK_I,
    input wire logic        RST_B_I,
    input wire logic [7:0]  REG_ADDR_I,
    input wire logic [7:0]  REG_WDATA_I,
    input wire logic        REG_WR_I,
    input wire logic        REG_RD_I,
    input wire logic [7:0]  REG_RDATA_O,
    input wire logic        ADDR_SEL_PIN_I,
    input wire logic [1:0]  ACCEL_RANGE_I,
    input wire logic [47:0] ACCEL_RAW_I,
    input wire logic [47:0] ACCEL_OUT_O,
    input wire logic        QUEUE_OVERRUN_FLAG_O,
    input wire logic [6:0]  I2C_ADDR_O
);
    logic signed [14:0] tx_ff;
    logic signed [19:0] sum;
    logic [15:0]        exp_x;
    wire  logic         mapped;
    wire  logic [1:0]   ax;
    wire  logic         fbit;
    assign mapped = REG_ADDR_I inside {[8'h72:8'h75], 8'h77, 8'h78, 8'h7A, 8'h7B, 8'h7D, 8'h7E};
    assign ax = (REG_ADDR_I == 8'h78) ? 2'h0 : (REG_ADDR_I == 8'h7B) ? 2'h1 : 2'h2;
    assign fbit = FACTORY_BIT0[ax];
    assign sum = $signed(ACCEL_RAW_I[15:0]) + (tx_ff <<< (3'h4 - ACCEL_RANGE_I));
    assign exp_x = (sum > 32767) ? 16'h7FFF : (sum < -32768) ? 16'h8000 : sum[15:0];
    // Mirror of the X trim value as the host writes it.
    always_ff @(posedge CLOCK_I or negedge RST_B_I)
        if (!RST_B_I)
            tx_ff <= '0;
        else if (REG_WR_I && REG_ADDR_I == ADDR_TRIM_HI[0])
            tx_ff[14:7] <= REG_WDATA_I;
        else if (REG_WR_I && REG_ADDR_I == ADDR_TRIM_LO[0])
            tx_ff[6:0] <= REG_WDATA_I[7:1];
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);
    chk_rdata_hold: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
        else $error("read data moved without a read");
    chk_ident_value: assert property ((REG_RD_I && REG_ADDR_I == ADDR_IDENT) |=>
        REG_RDATA_O == ID_CODE) else $error("identity code wrong");
    chk_unmapped_zero: assert property ((REG_RD_I && !mapped) |=> REG_RDATA_O == 8'h00)
        else $error("unmapped read not zero");
    chk_count_upper: assert property ((REG_RD_I && REG_ADDR_I == ADDR_COUNT_HI) |=>
        REG_RDATA_O[7:5] == 3'h0) else $error("count upper byte too wide");
    chk_trim_factory: assert property ((REG_RD_I && REG_ADDR_I inside {8'h78, 8'h7B, 8'h7E})
        |=> REG_RDATA_O[0] == $past(fbit)) else $error("factory bit lost");
    chk_addr_prefix: assert property (I2C_ADDR_O[6:1] == I2C_ADDR_HI)
        else $error("bus address prefix wrong");
    chk_addr_follow: assert property ((ADDR_SEL_PIN_I == $past(ADDR_SEL_PIN_I))[*8]
        |-> I2C_ADDR_O[0] == ADDR_SEL_PIN_I) else $error("bus address ignores pin");
    chk_accel_trim: assert property (!REG_WR_I |=>
        ACCEL_OUT_O[15:0] == $past(exp_x)) else $error("trimmed X output wrong");
    cover property (QUEUE_OVERRUN_FLAG_O);
    cover property (REG_RD_I && REG_ADDR_I == ADDR_PORT ##1 REG_RDATA_O == EMPTY_MARK);
    cover property (REG_WR_I && REG_ADDR_I == ADDR_TRIM_LO[0]);
endmodule : sqt_chk
bind sqt_top sqt_chk #(.ID_CODE(ID_CODE), .FACTORY_BIT0(FACTORY_BIT0)) u_chk (
    .CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_RDATA_O(REG_RDATA_O), .ADDR_SEL_PIN_I(ADDR_SEL_PIN_I),
    .ACCEL_RANGE_I(ACCEL_RANGE_I), .ACCEL_RAW_I(ACCEL_RAW_I), .ACCEL_OUT_O(ACCEL_OUT_O),
    .QUEUE_OVERRUN_FLAG_O(QUEUE_OVERRUN_FLAG_O), .I2C_ADDR_O(I2C_ADDR_O));
`default_nettype wire

// [sqt_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module sqt_top_tb_top
    import sqt_pkg::*;
();
    localparam logic [7:0] MY_ID = 8'h3C; // Arbitrary identity value.
    localparam logic [2:0] FB    = 3'h5;
    logic        clk, rst_b, pin, stop;
    logic [1:0]  rng;
    logic [13:0] en;
    logic [47:0] raw, aout;
    logic [63:0] oth;
    logic [7:0]  addr, wdata, rdata, b;
    logic [6:0]  i2c;
    logic        wr, rd, tick, ovf;
    logic [15:0] w;
    logic [14:0] trim [3];
    logic [7:0]  q[$], e[$];
    int          failures, checks_done, cyc, ovf_n, seed;
    sqt_host host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd), .tick_o(tick));
    sqt_top #(.DEPTH(16), .ID_CODE(MY_ID), .FACTORY_BIT0(FB)) DUT (
        .CLOCK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .SAMPLE_TICK_I(tick),
        .ADDR_SEL_PIN_I(pin), .CAPTURE_EN_I(en), .STOP_WHEN_FULL_I(stop),
        .ACCEL_RANGE_I(rng), .ACCEL_RAW_I(raw), .OTHER_DATA_I(oth), .ACCEL_OUT_O(aout),
        .QUEUE_OVERRUN_FLAG_O(ovf), .I2C_ADDR_O(i2c));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] acc(input logic [15:0] r, input logic [14:0] t,
                                        input logic [1:0] g);
        logic signed [19:0] s;
        s = $signed(r) + ($signed(t) <<< (3'h4 - g));
        acc = (s > 32767) ? 16'h7FFF : (s < -32768) ? 16'h8000 : s[15:0];
    endfunction : acc
    task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
        checks_done++;
        if (g !== x)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic push(input logic [7:0] v);
        if (e.size() < 16 || !stop)
        begin
            if (e.size() == 16)
                void'(e.pop_front());
            e.push_back((v == 8'hFF) ? 8'hFE : v);
        end
    endtask : push
    task automatic cmpq();
        host.drain(q);
        chk("queue depth", 16'(e.size()), 16'(q.size()));
        foreach (e[i])
            chk("queue byte", e[i], (i < q.size()) ? q[i] : 8'hFF);
        e.delete();
    endtask : cmpq
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (ovf === 1'b1)
            ovf_n++;
        if (cyc == 20000)
        begin
            failures++;
            wrap_up();
        end
    end
    initial
    begin
        seed = 78;
        rst_b = 1'b0;
        pin = 1'b0;
        stop = 1'b0;
        rng = 2'($random(seed));
        en = 14'h0000;
        raw = {$random(seed), 16'h7FF0};
        oth = 64'h0;
        repeat (3) @(posedge clk);
        #1;
        rst_b = 1'b1;
        host.rd(ADDR_IDENT, b);
        chk("identity", MY_ID, b);
        host.wr(ADDR_IDENT, 8'h00);
        host.rd(ADDR_IDENT, b);
        chk("identity after write", MY_ID, b);
        host.rd(8'h76, b);
        chk("unmapped read", 8'h00, b);
        host.rd(ADDR_PORT, b);
        chk("empty port", EMPTY_MARK, b);
        $display("test identity done");
        for (int a = 0; a < 3; a++)
        begin
            trim[a] = (a == 0) ? 15'h0040 : 15'($random(seed) % 300);
            host.trim_set(a, trim[a]);
            host.rd(ADDR_TRIM_HI[a], b);
            chk("trim high", trim[a][14:7], b);
            host.rd(ADDR_TRIM_LO[a], b);
            chk("trim low", {trim[a][6:0], FB[a]}, b);
        end
        for (int g = 0; g < 4; g++)
        begin
            rng = rng + 2'h1;
            @(posedge clk);
            #1;
            for (int a = 0; a < 3; a++)
                chk("accel out", acc(raw[16*a+:16], trim[a], rng), aout[16*a+:16]);
        end
        $display("test trim done");
        for (int k = 0; k < 4; k++)
        begin
            en = (k == 0) ? 14'h3FFF : 14'($random(seed));
            oth = {$random(seed), $random(seed)};
            oth[7:0] = 8'hFF;
            host.frame();
            repeat (40) @(posedge clk);
            for (int s = 0; s < 14; s++)
            begin
                w = acc(raw[16*(s/2%3)+:16], trim[s/2%3], rng);
                if (en[s])
                    push((s < 6) ? (s[0] ? w[7:0] : w[15:8]) : oth[8*(13-s)+:8]);
            end
            host.rd(ADDR_COUNT_HI, b);
            chk("count high", 8'h00, b);
            host.rd(ADDR_COUNT_LO, b);
            chk("count low", 8'(e.size()), b);
            cmpq();
        end
        $display("test capture done");
        for (int m = 0; m < 2; m++)
        begin
            stop = (m == 1);
            ovf_n = 0;
            for (int i = 0; i < 17; i++)
            begin
                b = (i == 3) ? 8'hFF : 8'(i + 16 * m + 1);
                push(b);
                host.wr(ADDR_PORT, b);
            end
            @(posedge clk);
            #1;
            chk("overrun pulses", 16'h0001, 16'(ovf_n));
            cmpq();
        end
        $display("test overflow done");
        pin = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk("bus address high", 7'h69, i2c);
        pin = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        chk("bus address low", 7'h68, i2c);
        $display("test address done");
        wrap_up();
    end
endmodule : sqt_top_tb_top
`default_nettype wire
